// [rtl/lod_decoder.sv]
// Byte-serial decoder for the AND memory forms and the OR immediate forms.
// Assumes fetch presents one byte per cycle with byte_valid_in, on ref_clk_in.
`timescale 1ns/1ps
module lod_decoder
(
   input wire logic ref_clk_in,                  // Core clock, 20 MHz
   input wire logic nrst_in,                     // Asynchronous reset, active low
   input wire logic [7:0] byte_in,               // Instruction byte from fetch
   input wire logic byte_valid_in,               // byte_in holds a new byte
   input wire logic flush_in,                    // Abandon a partly collected instruction
   output logic done_out,                        // One-cycle pulse: decode fields valid
   output logic illegal_out,                     // One-cycle pulse: unknown encoding
   output lod_pkg::lod_op_t op_out,              // Operation
   output lod_pkg::lod_mode_t mode_out,          // Addressing mode
   output lod_pkg::lod_base_t base_out,          // Pointer or base register
   output lod_pkg::lod_index_t index_out,        // Index register
   output lod_pkg::lod_step_t step_out,          // Pointer post-update
   output logic store_out,                       // 1 store to memory, 0 load to register
   output logic [3:0] reg_sel_out,               // General register number
   output logic [2:0] len_out,                   // Instruction length in bytes
   output logic [23:0] offset_out,               // Displacement or 24-bit offset
   output logic [7:0] imm_out,                   // Immediate operand
   output logic [7:0] page_out                   // Page or window register offset
);
   import lod_pkg::*;

   typedef struct packed
   {
      logic [2:0] cnt;
      logic [MAX_BYTES-1:0][7:0] bytes;
      logic done;
      logic illegal;
      lod_op_t op;
      lod_mode_t mode;
      lod_base_t base;
      lod_index_t index;
      lod_step_t step;
      logic store;
      logic [3:0] reg_sel;
      logic [2:0] len;
      logic [23:0] offset;
      logic [7:0] imm;
      logic [7:0] page;
   } lod_state_t;

   lod_state_t st_ff;
   lod_state_t nxt_st;
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic [7:0] c_b1;
   logic [7:0] c_b2;
   logic c_first_ok;
   logic c_legal;
   logic [2:0] c_len;
   lod_op_t c_op;
   lod_mode_t c_mode;
   lod_base_t c_base;
   lod_index_t c_index;
   lod_step_t c_step;
   logic c_store;

   // Reset release through two flip-flops
   always_ff @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // Table sees the arriving byte while it is the first or second one
   assign c_b1 = (st_ff.cnt == 3'h0) ? byte_in : st_ff.bytes[0];
   assign c_b2 = (st_ff.cnt == 3'h1) ? byte_in : st_ff.bytes[1];

   lod_classify u_classify
   (
      .b1_in(c_b1),
      .b2_in(c_b2),
      .first_ok_out(c_first_ok),
      .legal_out(c_legal),
      .len_out(c_len),
      .op_out(c_op),
      .mode_out(c_mode),
      .base_out(c_base),
      .index_out(c_index),
      .step_out(c_step),
      .store_out(c_store)
   );

   // Byte collection and field extraction
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.illegal = 1'b0;
      if (flush_in)
         nxt_st.cnt = 3'h0;
      else if (byte_valid_in)
      begin
         if (st_ff.cnt < LEN_5)
            nxt_st.bytes[st_ff.cnt] = byte_in;
         if (st_ff.cnt == 3'h0)
         begin
            if (c_first_ok)
               nxt_st.cnt = 3'h1;
            else
               nxt_st.illegal = 1'b1;
         end
         else if ((st_ff.cnt == 3'h1) && !c_legal)
         begin
            nxt_st.illegal = 1'b1;
            nxt_st.cnt = 3'h0;
         end
         else if ((st_ff.cnt + 3'h1) == c_len)
         begin
            // Last byte: publish the whole decode at once
            nxt_st.cnt = 3'h0;
            nxt_st.done = 1'b1;
            nxt_st.op = c_op;
            nxt_st.mode = c_mode;
            nxt_st.base = c_base;
            nxt_st.index = c_index;
            nxt_st.step = c_step;
            nxt_st.store = c_store;
            nxt_st.len = c_len;
            nxt_st.reg_sel = 4'h0;
            nxt_st.offset = 24'h000000;
            nxt_st.imm = 8'h00;
            nxt_st.page = 8'h00;
            unique case (c_mode)
               MODE_BASED: nxt_st.offset = {16'h0000, nxt_st.bytes[2]};
               MODE_OFF24: nxt_st.offset = {nxt_st.bytes[4], nxt_st.bytes[3],
                                            nxt_st.bytes[2]};
               MODE_ACC_IMM: nxt_st.imm = nxt_st.bytes[1];
               MODE_REG_IMM:
               begin
                  nxt_st.reg_sel = nxt_st.bytes[1][7:4];
                  nxt_st.imm = nxt_st.bytes[2];
               end
               MODE_PAGE2:
               begin
                  nxt_st.page = nxt_st.bytes[1];
                  nxt_st.imm = nxt_st.bytes[2];
               end
               MODE_PAGE1, MODE_SFR:
               begin
                  nxt_st.page = nxt_st.bytes[2];
                  nxt_st.imm = nxt_st.bytes[3];
               end
               default: ;
            endcase
         end
         else
            nxt_st.cnt = st_ff.cnt + 3'h1;
      end
   end

   // State register
   always_ff @(posedge ref_clk_in or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // Outputs straight from the state register
   assign done_out = st_ff.done;
   assign illegal_out = st_ff.illegal;
   assign op_out = st_ff.op;
   assign mode_out = st_ff.mode;
   assign base_out = st_ff.base;
   assign index_out = st_ff.index;
   assign step_out = st_ff.step;
   assign store_out = st_ff.store;
   assign reg_sel_out = st_ff.reg_sel;
   assign len_out = st_ff.len;
   assign offset_out = st_ff.offset;
   assign imm_out = st_ff.imm;
   assign page_out = st_ff.page;

   // Checks on the decode results
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_sync_ff);

   logic take1;
   assign take1 = byte_valid_in && !flush_in && (st_ff.cnt == 3'h1);

   a_and_load: assert property (take1 && st_ff.bytes[0] == OPC_AND_IDX && byte_in == 8'h4c
      |=> done_out && !store_out && base_out == BASE_PTR24_THIRD
      && index_out == INDEX_PAIR_D_E && len_out == LEN_2)
      else $error("load form decoded wrongly");
   a_and_idx_store: assert property (take1 && st_ff.bytes[0] == OPC_AND_IDX && byte_in == 8'hec
      |=> done_out && store_out && base_out == BASE_PTR24_FIRST
      && index_out == INDEX_GP_REG_THREE)
      else $error("indexed store decoded wrongly");
   a_and_ptr_store: assert property (take1 && st_ff.bytes[0] == OPC_AND_PTR && byte_in == 8'hac
      |=> done_out && step_out == STEP_DEC && base_out == BASE_PTR24_FIRST)
      else $error("pointer store decoded wrongly");
   a_based_disp: assert property (done_out && mode_out == MODE_BASED
      |-> len_out == LEN_3 && offset_out == {16'h0000, $past(byte_in)})
      else $error("based displacement wrong");
   a_off24_order: assert property (done_out && mode_out == MODE_OFF24
      |-> len_out == LEN_5 && offset_out[23:16] == $past(byte_in))
      else $error("24-bit offset order wrong");
   a_or_acc_imm: assert property (take1 && st_ff.bytes[0] == OPC_OR_ACC
      |=> done_out && op_out == OP_OR && imm_out == $past(byte_in)
      && len_out == LEN_2)
      else $error("accumulator immediate wrong");
   a_or_reg_imm: assert property (done_out && mode_out == MODE_REG_IMM
      |-> len_out == LEN_3 && imm_out == $past(byte_in) && !store_out)
      else $error("register immediate wrong");
   a_or_page2: assert property (done_out && mode_out == MODE_PAGE2
      |-> len_out == LEN_3 && store_out && imm_out == $past(byte_in))
      else $error("page two form wrong");
   a_or_page1: assert property (done_out && mode_out == MODE_PAGE1
      |-> len_out == LEN_4 && imm_out == $past(byte_in))
      else $error("page one form wrong");
   a_or_sfr: assert property (done_out && mode_out == MODE_SFR
      |-> len_out == LEN_4 && store_out && imm_out == $past(byte_in))
      else $error("window register form wrong");
   a_bad_first: assert property (byte_valid_in && !flush_in && st_ff.cnt == 3'h0
      && byte_in == 8'hff |=> illegal_out && !done_out)
      else $error("unknown first byte not flagged");
   a_never_both: assert property (!(done_out && illegal_out))
      else $error("done and illegal together");

   c_and_store: cover property (done_out && op_out == OP_AND && store_out);
   c_or_prefix: cover property (done_out && mode_out == MODE_SFR);
   c_off24: cover property (done_out && mode_out == MODE_OFF24);
   c_illegal: cover property (illegal_out);
endmodule

// [inc/lod_pkg.sv]
// Constants and types shared by the logic-op opcode decoder.
// Assumes one core clock and bytes delivered in program order by fetch.
// Notes on behaviour
// - 17h plus 0xxx1100 is AND memory into accumulator, base-plus-index selected by code.
// - 17h plus 1xxx1100 is AND stored to base-plus-index memory, eight codes.
// - 16h plus 1xxx1100 is AND stored through pointer, with increment or decrement for codes 0 to 3 only.
// - 06h plus 1xxx1100 plus displacement byte is AND stored at base plus byte.
// - 0Ah plus 1xxx1100 is AND stored at 24-bit offset plus index, low byte first.
// - AEh then immediate byte is OR of accumulator with immediate.
// - 7Eh, then register nibble with 0011, then immediate, is OR register immediate.
// - 6Eh, page-two offset, immediate is OR into short direct page two.
// - Prefix 3Ch then 6Eh, offset, immediate is OR into short direct page one.
// - Prefix 01h then 6Eh, offset, immediate is OR into special function window.
package lod_pkg;
   // First bytes
   localparam logic [7:0] OPC_AND_IDX = 8'h17;
   localparam logic [7:0] OPC_AND_PTR = 8'h16;
   localparam logic [7:0] OPC_AND_BASED = 8'h06;
   localparam logic [7:0] OPC_AND_OFF24 = 8'h0a;
   localparam logic [7:0] OPC_OR_ACC = 8'hae;
   localparam logic [7:0] OPC_OR_REG = 8'h7e;
   localparam logic [7:0] OPC_OR_PAGE = 8'h6e;
   localparam logic [7:0] OPC_PFX_PAGE1 = 8'h3c;
   localparam logic [7:0] OPC_PFX_SFR = 8'h01;
   // Second-byte fields
   localparam logic [3:0] AND_LOW_NIB = 4'hc;
   localparam logic [3:0] OR_REG_LOW_NIB = 4'h3;
   localparam int STORE_BIT = 7;
   localparam logic [2:0] BASED_MAX_CODE = 3'h4;
   localparam logic [2:0] OFF24_MAX_CODE = 3'h3;
   // Instruction lengths in bytes
   localparam logic [2:0] LEN_NONE = 3'h0;
   localparam logic [2:0] LEN_2 = 3'h2;
   localparam logic [2:0] LEN_3 = 3'h3;
   localparam logic [2:0] LEN_4 = 3'h4;
   localparam logic [2:0] LEN_5 = 3'h5;
   localparam int MAX_BYTES = 5;

   typedef enum logic [1:0] {OP_NONE = 2'b00, OP_AND = 2'b01, OP_OR = 2'b10} lod_op_t;
   typedef enum logic [3:0]
   {
      MODE_NONE = 4'b0000,
      MODE_BASE_INDEX = 4'b0001,
      MODE_POINTER = 4'b0010,
      MODE_BASED = 4'b0011,
      MODE_OFF24 = 4'b0100,
      MODE_ACC_IMM = 4'b0101,
      MODE_REG_IMM = 4'b0110,
      MODE_PAGE2 = 4'b0111,
      MODE_PAGE1 = 4'b1000,
      MODE_SFR = 4'b1001
   } lod_mode_t;
   typedef enum logic [2:0]
   {
      BASE_NONE = 3'b000,
      BASE_PTR24_FIRST = 3'b001,
      BASE_PTR24_SECOND = 3'b010,
      BASE_PTR24_THIRD = 3'b011,
      BASE_PTR24_FOURTH = 3'b100,
      BASE_STACK_POINTER = 3'b101
   } lod_base_t;
   typedef enum logic [2:0]
   {
      INDEX_NONE = 3'b000,
      INDEX_ACC = 3'b001,
      INDEX_GP_REG_TWO = 3'b010,
      INDEX_GP_REG_THREE = 3'b011,
      INDEX_PAIR_D_E = 3'b100,
      INDEX_PAIR_H_L = 3'b101
   } lod_index_t;
   typedef enum logic [1:0] {STEP_NONE = 2'b00, STEP_INC = 2'b01, STEP_DEC = 2'b10} lod_step_t;
endpackage

// [rtl/lod_classify.sv]
// Combinational opcode table: first and second byte to operation and operands.
// Assumes the caller only trusts legal_out once the second byte is present.
`timescale 1ns/1ps
module lod_classify
(
   input wire logic [7:0] b1_in,                 // First instruction byte
   input wire logic [7:0] b2_in,                 // Second instruction byte
   output logic first_ok_out,                    // First byte is a known opcode or prefix
   output logic legal_out,                       // Byte pair forms a known instruction
   output logic [2:0] len_out,                   // Total length in bytes
   output lod_pkg::lod_op_t op_out,              // Operation
   output lod_pkg::lod_mode_t mode_out,          // Addressing mode
   output lod_pkg::lod_base_t base_out,          // Pointer or base register
   output lod_pkg::lod_index_t index_out,        // Index register
   output lod_pkg::lod_step_t step_out,          // Pointer update
   output logic store_out                        // Result goes to memory
);
   import lod_pkg::*;
   logic [2:0] code;
   logic and_form;
   assign code = b2_in[6:4];
   assign and_form = (b2_in[3:0] == AND_LOW_NIB);

   // Opcode table
   always_comb
   begin
      first_ok_out = 1'b1;
      legal_out = 1'b0;
      len_out = LEN_NONE;
      op_out = OP_NONE;
      mode_out = MODE_NONE;
      base_out = BASE_NONE;
      index_out = INDEX_NONE;
      step_out = STEP_NONE;
      store_out = 1'b0;
      case (b1_in)
         OPC_AND_IDX:
         begin
            legal_out = and_form;
            len_out = LEN_2;
            op_out = OP_AND;
            mode_out = MODE_BASE_INDEX;
            store_out = b2_in[STORE_BIT];
            base_out = code[0] ? BASE_PTR24_SECOND : BASE_PTR24_FIRST;
            if (code[2:1] == 2'h2)
               base_out = BASE_PTR24_THIRD;
            unique case (code)
               3'h0, 3'h1: index_out = INDEX_ACC;
               3'h2, 3'h3: index_out = INDEX_GP_REG_TWO;
               3'h4: index_out = INDEX_PAIR_D_E;
               3'h5: index_out = INDEX_PAIR_H_L;
               3'h6, 3'h7: index_out = INDEX_GP_REG_THREE;
            endcase
         end
         OPC_AND_PTR:
         begin
            legal_out = and_form && b2_in[STORE_BIT];
            len_out = LEN_2;
            op_out = OP_AND;
            mode_out = MODE_POINTER;
            store_out = 1'b1;
            base_out = code[0] ? BASE_PTR24_SECOND : BASE_PTR24_FIRST;
            if (code == 3'h6)
               base_out = BASE_PTR24_THIRD;
            if (code == 3'h7)
               base_out = BASE_PTR24_FOURTH;
            if (!code[2])
               step_out = code[1] ? STEP_DEC : STEP_INC;
         end
         OPC_AND_BASED:
         begin
            legal_out = and_form && b2_in[STORE_BIT] && (code <= BASED_MAX_CODE);
            len_out = LEN_3;
            op_out = OP_AND;
            mode_out = MODE_BASED;
            store_out = 1'b1;
            unique case (code)
               3'h0: base_out = BASE_PTR24_FIRST;
               3'h1: base_out = BASE_STACK_POINTER;
               3'h2: base_out = BASE_PTR24_SECOND;
               3'h3: base_out = BASE_PTR24_FOURTH;
               default: base_out = BASE_PTR24_THIRD;
            endcase
         end
         OPC_AND_OFF24:
         begin
            legal_out = and_form && b2_in[STORE_BIT] && (code <= OFF24_MAX_CODE);
            len_out = LEN_5;
            op_out = OP_AND;
            mode_out = MODE_OFF24;
            store_out = 1'b1;
            unique case (code[1:0])
               2'h0: index_out = INDEX_PAIR_D_E;
               2'h1: index_out = INDEX_ACC;
               2'h2: index_out = INDEX_PAIR_H_L;
               2'h3: index_out = INDEX_GP_REG_TWO;
            endcase
         end
         OPC_OR_ACC:
         begin
            legal_out = 1'b1;
            len_out = LEN_2;
            op_out = OP_OR;
            mode_out = MODE_ACC_IMM;
         end
         OPC_OR_REG:
         begin
            legal_out = (b2_in[3:0] == OR_REG_LOW_NIB);
            len_out = LEN_3;
            op_out = OP_OR;
            mode_out = MODE_REG_IMM;
         end
         OPC_OR_PAGE:
         begin
            legal_out = 1'b1;
            len_out = LEN_3;
            op_out = OP_OR;
            mode_out = MODE_PAGE2;
            store_out = 1'b1;
         end
         OPC_PFX_PAGE1, OPC_PFX_SFR:
         begin
            legal_out = (b2_in == OPC_OR_PAGE);
            len_out = LEN_4;
            op_out = OP_OR;
            mode_out = (b1_in == OPC_PFX_SFR) ? MODE_SFR : MODE_PAGE1;
            store_out = 1'b1;
         end
         default: first_ok_out = 1'b0;
      endcase
   end
endmodule

// [verification/lod_fetch_model.sv]
// Fetch-stage stand-in that feeds queued instruction bytes to the decoder.
// Assumes the bench pushes bytes only after the decoder's reset has settled.
`timescale 1ns/1ps
module lod_fetch_model
(
   input wire logic ref_clk_in,  // Core clock
   input wire logic slow_in,     // Insert random idle cycles between bytes
   output logic [7:0] byte_out,  // Instruction byte
   output logic byte_valid_out,  // Byte present this cycle
   output logic flush_out,       // Drop the partly collected instruction
   output logic last_out,        // Byte ends an instruction
   output logic idle_out         // Nothing left to send
);
   logic [9:0] q[$];
   logic [9:0] w;

   // Quiet start
   initial
   begin
      byte_out = 8'h00;
      byte_valid_out = 1'b0;
      flush_out = 1'b0;
      last_out = 1'b0;
      idle_out = 1'b1;
   end

   // Entry is {flush, last, byte}
   task automatic push(input logic [9:0] v);
      q.push_back(v);
   endtask

   // Send the oldest byte; between bytes the line keeps changing so stale data is never reused
   always @(posedge ref_clk_in)
   begin
      if (q.size() != 0 && (!slow_in || $urandom_range(2) == 0))
      begin
         w = q.pop_front();
         byte_out <= w[7:0];
         last_out <= w[8];
         flush_out <= w[9];
         byte_valid_out <= 1'b1;
      end
      else
      begin
         byte_out <= ~byte_out;
         last_out <= 1'b0;
         flush_out <= 1'b0;
         byte_valid_out <= 1'b0;
      end
      idle_out <= (q.size() == 0);
   end
endmodule

// [verification/lod_decoder_tb.sv]
// Self-checking bench for the logic-op opcode decoder.
// Assumes lod_pkg and the design are compiled first; the fetch model drives all bytes.
`timescale 1ns/1ps
module lod_decoder_tb;
   import lod_pkg::*;
   typedef struct packed
   {
      logic bad;
      lod_op_t op;
      lod_mode_t mode;
      lod_base_t base;
      lod_index_t index;
      lod_step_t step;
      logic st;
      logic [3:0] rs;
      logic [2:0] len;
      logic [23:0] off;
      logic [7:0] imm;
      logic [7:0] pg;
   } lod_tb_exp_t;

   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic slow = 1'b0;
   logic [7:0] byte_in;
   logic byte_valid_in, flush_in, fm_last, fm_idle, due = 1'b0;
   logic done_out, illegal_out, store_out;
   lod_op_t op_out;
   lod_mode_t mode_out;
   lod_base_t base_out;
   lod_index_t index_out;
   lod_step_t step_out;
   logic [3:0] reg_sel_out;
   logic [2:0] len_out;
   logic [23:0] offset_out;
   logic [7:0] imm_out, page_out;
   int n_errors = 0;
   int n_tests = 0;
   logic [7:0] ib[$];
   lod_tb_exp_t eq[$];
   lod_tb_exp_t e;
   lod_tb_exp_t bad_e = '{1'b1, OP_NONE, MODE_NONE, BASE_NONE, INDEX_NONE, STEP_NONE,
      1'b0, 4'h0, 3'h0, 24'h0, 8'h0, 8'h0};
   lod_base_t bx_base[8] = '{BASE_PTR24_FIRST, BASE_PTR24_SECOND, BASE_PTR24_FIRST,
      BASE_PTR24_SECOND, BASE_PTR24_THIRD, BASE_PTR24_THIRD, BASE_PTR24_FIRST, BASE_PTR24_SECOND};
   lod_index_t bx_idx[8] = '{INDEX_ACC, INDEX_ACC, INDEX_GP_REG_TWO, INDEX_GP_REG_TWO,
      INDEX_PAIR_D_E, INDEX_PAIR_H_L, INDEX_GP_REG_THREE, INDEX_GP_REG_THREE};
   lod_base_t pt_base[8] = '{BASE_PTR24_FIRST, BASE_PTR24_SECOND, BASE_PTR24_FIRST,
      BASE_PTR24_SECOND, BASE_PTR24_FIRST, BASE_PTR24_SECOND, BASE_PTR24_THIRD, BASE_PTR24_FOURTH};
   lod_step_t pt_step[8] = '{STEP_INC, STEP_INC, STEP_DEC, STEP_DEC,
      STEP_NONE, STEP_NONE, STEP_NONE, STEP_NONE};
   lod_base_t bs_base[5] = '{BASE_PTR24_FIRST, BASE_STACK_POINTER, BASE_PTR24_SECOND,
      BASE_PTR24_FOURTH, BASE_PTR24_THIRD};
   lod_index_t of_idx[4] = '{INDEX_PAIR_D_E, INDEX_ACC, INDEX_PAIR_H_L, INDEX_GP_REG_TWO};

   lod_fetch_model fm_inst (.ref_clk_in(ref_clk_in), .slow_in(slow), .byte_out(byte_in),
      .byte_valid_out(byte_valid_in), .flush_out(flush_in), .last_out(fm_last),
      .idle_out(fm_idle));

   lod_decoder lod_decoder_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .byte_in(byte_in),
      .byte_valid_in(byte_valid_in), .flush_in(flush_in), .done_out(done_out),
      .illegal_out(illegal_out), .op_out(op_out), .mode_out(mode_out), .base_out(base_out),
      .index_out(index_out), .step_out(step_out), .store_out(store_out),
      .reg_sel_out(reg_sel_out), .len_out(len_out), .offset_out(offset_out),
      .imm_out(imm_out), .page_out(page_out));

   // Core clock, 50 ns period
   always #25 ref_clk_in = ~ref_clk_in;

   task automatic finish_test();
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, x, g);
      end
   endtask

   function automatic lod_tb_exp_t ex(input lod_op_t o, input lod_mode_t m, input lod_base_t b,
      input lod_index_t x, input lod_step_t s, input logic st, input logic [2:0] n,
      input logic [23:0] f, input logic [7:0] im, input logic [7:0] p, input logic [3:0] g);
      ex = '{1'b0, o, m, b, x, s, st, g, n, f, im, p};
   endfunction

   // Note the expectation, then hand the bytes to fetch with the last one marked
   task automatic go(input lod_tb_exp_t x);
      eq.push_back(x);
      foreach (ib[i])
         fm_inst.push({1'b0, i == ib.size() - 1, ib[i]});
      ib.delete();
   endtask

   task automatic run_all(input logic s);
      logic [31:0] r;
      slow <= s;
      for (int c = 0; c < 8; c++)
      begin
         for (int t = 0; t < 2; t++)
         begin
            ib = '{8'h17, {t[0], c[2:0], 4'hc}};
            go(ex(OP_AND, MODE_BASE_INDEX, bx_base[c], bx_idx[c], STEP_NONE, t[0], 3'h2,
               24'h0, 8'h0, 8'h0, 4'h0));
         end
         ib = '{8'h16, {1'b1, c[2:0], 4'hc}};
         go(ex(OP_AND, MODE_POINTER, pt_base[c], INDEX_NONE, pt_step[c], 1'b1, 3'h2,
            24'h0, 8'h0, 8'h0, 4'h0));
         r = $urandom;
         ib = '{8'h06, {1'b1, c[2:0], 4'hc}};
         if (c < 5)
         begin
            ib.push_back(r[7:0]);
            go(ex(OP_AND, MODE_BASED, bs_base[c], INDEX_NONE, STEP_NONE, 1'b1, 3'h3,
               {16'h0, r[7:0]}, 8'h0, 8'h0, 4'h0));
         end
         else
            go(bad_e);
         ib = '{8'h0a, {1'b1, c[2:0], 4'hc}};
         if (c < 4)
         begin
            ib = '{8'h0a, {1'b1, c[2:0], 4'hc}, r[7:0], r[15:8], r[23:16]};
            go(ex(OP_AND, MODE_OFF24, BASE_NONE, of_idx[c], STEP_NONE, 1'b1, 3'h5,
               r[23:0], 8'h0, 8'h0, 4'h0));
         end
         else
            go(bad_e);
      end
      for (int g = 0; g < 16; g++)
      begin
         r = $urandom;
         ib = '{8'h7e, {g[3:0], 4'h3}, r[7:0]};
         go(ex(OP_OR, MODE_REG_IMM, BASE_NONE, INDEX_NONE, STEP_NONE, 1'b0, 3'h3,
            24'h0, r[7:0], 8'h0, g[3:0]));
      end
      r = $urandom;
      ib = '{8'hae, r[7:0]};
      go(ex(OP_OR, MODE_ACC_IMM, BASE_NONE, INDEX_NONE, STEP_NONE, 1'b0, 3'h2,
         24'h0, r[7:0], 8'h0, 4'h0));
      ib = '{8'h6e, r[15:8], r[7:0]};
      go(ex(OP_OR, MODE_PAGE2, BASE_NONE, INDEX_NONE, STEP_NONE, 1'b1, 3'h3,
         24'h0, r[7:0], r[15:8], 4'h0));
      ib = '{8'h3c, 8'h6e, r[23:16], r[31:24]};
      go(ex(OP_OR, MODE_PAGE1, BASE_NONE, INDEX_NONE, STEP_NONE, 1'b1, 3'h4,
         24'h0, r[31:24], r[23:16], 4'h0));
      ib = '{8'h01, 8'h6e, r[15:8], r[23:16]};
      go(ex(OP_OR, MODE_SFR, BASE_NONE, INDEX_NONE, STEP_NONE, 1'b1, 3'h4,
         24'h0, r[23:16], r[15:8], 4'h0));
      // Encodings outside the block are refused after the byte that exposes them
      ib = '{8'h16, 8'h4c};
      go(bad_e);
      ib = '{8'h17, 8'h0d};
      go(bad_e);
      ib = '{8'h7e, 8'h50};
      go(bad_e);
      ib = '{8'h3c, 8'h7e};
      go(bad_e);
      ib = '{8'hff};
      go(bad_e);
      // A flush drops the half-collected register form and its own byte
      fm_inst.push({2'b00, 8'h7e});
      fm_inst.push({2'b00, 8'h13});
      fm_inst.push({2'b10, 8'hae});
      ib = '{8'hae, r[31:24]};
      go(ex(OP_OR, MODE_ACC_IMM, BASE_NONE, INDEX_NONE, STEP_NONE, 1'b0, 3'h2,
         24'h0, r[31:24], 8'h0, 4'h0));
      repeat (3) @(posedge ref_clk_in);
      while (fm_idle !== 1'b1)
         @(posedge ref_clk_in);
      repeat (3) @(posedge ref_clk_in);
   endtask

   // A result is due exactly one cycle after the last byte is taken
   always @(posedge ref_clk_in)
      due <= nrst_in & byte_valid_in & ~flush_in & fm_last;

   // Watch the outputs and match every result against the oldest note
   always @(negedge ref_clk_in)
   begin
      if (nrst_in === 1'b1)
      begin
         chk("result time", {31'h0, due}, {31'h0, done_out | illegal_out});
         if (done_out === 1'b1 || illegal_out === 1'b1)
         begin
            if (eq.size() == 0)
               chk("spare result", 32'h0, 32'h1);
            else
            begin
               e = eq.pop_front();
               chk("illegal", e.bad, illegal_out);
               chk("done", !e.bad, done_out);
               if (e.bad == 1'b0)
               begin
                  chk("op", e.op, op_out);
                  chk("mode", e.mode, mode_out);
                  chk("base", e.base, base_out);
                  chk("index", e.index, index_out);
                  chk("step", e.step, step_out);
                  chk("store", e.st, store_out);
                  chk("reg", e.rs, reg_sel_out);
                  chk("len", e.len, len_out);
                  chk("offset", e.off, offset_out);
                  chk("imm", e.imm, imm_out);
                  chk("page", e.pg, page_out);
               end
            end
         end
      end
   end

   // Reset, then every form at full rate and again with fetch stalling
   initial
   begin
      void'($urandom(32'h82850d94));
      repeat (8) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      run_all(1'b0);
      run_all(1'b1);
      chk("pending", 32'h0, eq.size());
      finish_test();
   end

   // Cut a hang short
   initial
   begin
      repeat (20000) @(posedge ref_clk_in);
      n_errors++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      finish_test();
   end
endmodule
